// [include/pis_defines.svh]
// constants for the pci interrupt steering block
`ifndef PIS_DEFINES_SVH
`define PIS_DEFINES_SVH
`define PIS_NUM_PROG           8
`define PIS_NUM_LEGACY         16
`define PIS_NUM_ADV            24
`define PIS_ADV_PROG_BASE      16
`define PIS_CASCADE_IRQ        4'h2
`define PIS_ROUTE_DISABLED     4'h0
`define PIS_LEGACY_OK_MASK     16'hDEF8
`define PIS_FIXED_SRC_COUNT    4
`define PIS_SERIAL2_DEF_IRQ    4'h3
`define PIS_SERIAL1_DEF_IRQ    4'h4
`define PIS_PAR2_DEF_IRQ       4'h5
`define PIS_PAR1_DEF_IRQ       4'h7
`endif

// [include/pis_pkg.sv]
// types for the pci interrupt steering block
package pis_pkg;
	typedef logic [3:0] pis_irq_num_type;
	typedef enum logic {
		PIS_MODE_LEGACY,
		PIS_MODE_ADVANCED
	} pis_mode_type;
	typedef enum {
		PIS_ST_IDLE,
		PIS_ST_RUN
	} pis_state_type;
endpackage

// [verilog/pis_sync.sv]
// two-flop synchroniser bank for asynchronous request pins
`timescale 1ns/1ps
module pis_sync #(
	parameter int WIDTH = 8
) (
	input  wire logic             ref_clk_in,
	input  wire logic             reset_n_in,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	// ==========================================
	// synchroniser
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;
	// idle level of an active-low request line is high
	always_ff @(posedge ref_clk_in) begin
		if (!reset_n_in) begin
			meta_q <= '1;
			sync_q <= '1;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end
	assign sync_out = sync_q;
endmodule

// [verilog/pis_steering.sv]
// pci interrupt steering onto legacy and advanced controller inputs
// How it works
// [RULE_01] eight programmable request inputs; each pci source feeds exactly one.
// [RULE_02] legacy mode steers each input to line 3-7, 9-12, 14 or 15.
// [RULE_03] several programmable inputs may share one legacy line.
// [RULE_04] legacy controller output covers only interrupts 0 through 15.
// [RULE_05] advanced controller output has twenty-four inputs, 0 through 23.
// [RULE_06] advanced mode delivers inputs first to eighth onto 16 through 23.
// [RULE_07] interrupts 16 to 23 stay quiet in legacy mode.
// [RULE_08] legacy line 2 is kept for the cascade, never steered to.
// [RULE_09] sources tied onto one input form one shared request.
// [RULE_10] cards put their single or first interrupt on their first pin.
// [RULE_11] serial and parallel port interrupt numbers are programmable.
// [RULE_12] usb, serial storage, express port routes set at run time.
// [RULE_13] inputs are active low level shareable; request holds until all release.
`timescale 1ns/1ps
`include "pis_defines.svh"
module pis_steering
	import pis_pkg::*;
#(
	parameter int NUM_PROG  = `PIS_NUM_PROG,
	parameter int NUM_FIXED = `PIS_FIXED_SRC_COUNT,
	parameter int NUM_DYN   = 3
) (
	input  wire logic                     ref_clk_in,
	input  wire logic                     reset_n_in,
	input  wire logic [NUM_PROG-1:0]      prog_irq_input_n_in,
	input  wire logic                     adv_mode_in,
	input  wire logic [4*NUM_PROG-1:0]    prog_route_in,
	input  wire logic                     route_load_in,
	input  wire logic [NUM_FIXED-1:0]     fixed_req_in,
	input  wire logic [4*NUM_FIXED-1:0]   fixed_route_in,
	input  wire logic                     fixed_load_in,
	input  wire logic [NUM_DYN-1:0]       dyn_req_in,
	input  wire logic [3*NUM_DYN-1:0]     dyn_sel_in,
	input  wire logic                     dyn_load_in,
	output logic [`PIS_NUM_LEGACY-1:0]    legacy_irq_controller_out,
	output logic [`PIS_NUM_ADV-1:0]       advanced_irq_controller_out,
	output logic [NUM_PROG-1:0]           prog_active_out,
	output logic                          route_reject_out
);
	// ==========================================
	// request capture
	logic [NUM_PROG-1:0] prog_n_sync;
	pis_sync #(.WIDTH(NUM_PROG)) u_sync (
		.ref_clk_in (ref_clk_in),
		.reset_n_in (reset_n_in),
		.async_in   (prog_irq_input_n_in),
		.sync_out   (prog_n_sync)
	);
	// wired sharing means the pin is low while any source holds it
	wire [NUM_PROG-1:0] prog_req = ~prog_n_sync; // [RULE_13] [RULE_09]

	logic [NUM_FIXED-1:0] fixed_s1_q;
	logic [NUM_FIXED-1:0] fixed_s2_q;
	logic [NUM_DYN-1:0]   dyn_s1_q;
	logic [NUM_DYN-1:0]   dyn_s2_q;
	always_ff @(posedge ref_clk_in) begin
		if (!reset_n_in) begin
			fixed_s1_q <= '0;
			fixed_s2_q <= '0;
			dyn_s1_q   <= '0;
			dyn_s2_q   <= '0;
		end else begin
			fixed_s1_q <= fixed_req_in;
			fixed_s2_q <= fixed_s1_q;
			dyn_s1_q   <= dyn_req_in;
			dyn_s2_q   <= dyn_s1_q;
		end
	end

	// ==========================================
	// mode and route tables
	pis_mode_type    mode_q;
	pis_state_type   state_q;
	pis_irq_num_type route_q [NUM_PROG];
	pis_irq_num_type fixed_q [NUM_FIXED];
	logic [2:0]      dyn_q   [NUM_DYN];
	logic            reject_q;
	logic [NUM_PROG-1:0]  route_bad;
	logic [NUM_FIXED-1:0] fixed_bad;

	wire pis_mode_type mode_d = adv_mode_in ? PIS_MODE_ADVANCED : PIS_MODE_LEGACY;
	wire [`PIS_NUM_LEGACY-1:0] legal_mask = `PIS_LEGACY_OK_MASK;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_PROG; gi++) begin : g_prog
			wire pis_irq_num_type nr = prog_route_in[4*gi +: 4];
			// zero disables; line 2 and the fixed system lines are not legal targets
			assign route_bad[gi] = (nr != `PIS_ROUTE_DISABLED) && !legal_mask[nr]; // [RULE_02] [RULE_08]
			always_ff @(posedge ref_clk_in) begin
				if (!reset_n_in) begin
					route_q[gi] <= `PIS_ROUTE_DISABLED;
				end else if (route_load_in && !route_bad[gi]) begin
					route_q[gi] <= nr; // [RULE_02]
				end
			end
		end
		for (gi = 0; gi < NUM_FIXED; gi++) begin : g_fixed
			wire pis_irq_num_type nf = fixed_route_in[4*gi +: 4];
			assign fixed_bad[gi] = (nf == `PIS_CASCADE_IRQ); // [RULE_08]
			always_ff @(posedge ref_clk_in) begin
				if (!reset_n_in) begin
					unique case (gi)
						0: fixed_q[gi] <= `PIS_SERIAL1_DEF_IRQ;
						1: fixed_q[gi] <= `PIS_SERIAL2_DEF_IRQ;
						2: fixed_q[gi] <= `PIS_PAR1_DEF_IRQ;
						default: fixed_q[gi] <= `PIS_PAR2_DEF_IRQ;
					endcase
				end else if (fixed_load_in && !fixed_bad[gi]) begin
					fixed_q[gi] <= nf; // [RULE_11]
				end
			end
		end
		for (gi = 0; gi < NUM_DYN; gi++) begin : g_dyn
			always_ff @(posedge ref_clk_in) begin
				if (!reset_n_in) begin
					dyn_q[gi] <= 3'h0;
				end else if (dyn_load_in) begin
					dyn_q[gi] <= dyn_sel_in[3*gi +: 3]; // [RULE_12]
				end
			end
		end
	endgenerate

	wire any_reject = (route_load_in && (|route_bad)) || (fixed_load_in && (|fixed_bad));

	always_ff @(posedge ref_clk_in) begin
		if (!reset_n_in) begin
			mode_q   <= PIS_MODE_LEGACY;
			state_q  <= PIS_ST_IDLE;
			reject_q <= 1'b0;
		end else begin
			mode_q   <= mode_d;
			state_q  <= PIS_ST_RUN;
			reject_q <= any_reject;
		end
	end

	// ==========================================
	// combine requests
	// dynamic sources join a programmable line, so they share its steering
	logic [NUM_PROG-1:0] line_req;
	always_comb begin
		line_req = prog_req;
		for (int d = 0; d < NUM_DYN; d++) begin
			if (dyn_s2_q[d]) begin
				line_req[dyn_q[d]] = 1'b1; // [RULE_12] [RULE_09]
			end
		end
	end

	logic [`PIS_NUM_LEGACY-1:0] legacy_d;
	always_comb begin
		legacy_d = '0;
		if (mode_q == PIS_MODE_LEGACY) begin
			for (int p = 0; p < NUM_PROG; p++) begin
				if (line_req[p] && route_q[p] != `PIS_ROUTE_DISABLED) begin
					legacy_d[route_q[p]] = 1'b1; // [RULE_03]
				end
			end
		end
		for (int f = 0; f < NUM_FIXED; f++) begin
			if (fixed_s2_q[f]) begin
				legacy_d[fixed_q[f]] = 1'b1; // [RULE_11]
			end
		end
		legacy_d[`PIS_CASCADE_IRQ] = 1'b0; // [RULE_08]
	end

	logic [`PIS_NUM_ADV-1:0] adv_d;
	always_comb begin
		adv_d = '0;
		if (mode_q == PIS_MODE_ADVANCED) begin
			adv_d[`PIS_NUM_LEGACY-1:0] = legacy_d; // [RULE_05]
			adv_d[`PIS_ADV_PROG_BASE +: NUM_PROG] = line_req; // [RULE_06] [RULE_07]
		end
	end

	// ==========================================
	// outputs
	logic [`PIS_NUM_LEGACY-1:0] legacy_q;
	logic [`PIS_NUM_ADV-1:0]    adv_q;
	logic [NUM_PROG-1:0]        active_q;
	always_ff @(posedge ref_clk_in) begin
		if (!reset_n_in) begin
			legacy_q <= '0;
			adv_q    <= '0;
			active_q <= '0;
		end else begin
			legacy_q <= (mode_q == PIS_MODE_LEGACY) ? legacy_d : '0; // [RULE_04]
			adv_q    <= adv_d; // [RULE_05]
			active_q <= line_req; // [RULE_13]
		end
	end

	// nothing leaves before the first run cycle so stale tables never fire
	wire running = (state_q == PIS_ST_RUN);
	assign legacy_irq_controller_out   = running ? legacy_q : '0;
	assign advanced_irq_controller_out = running ? adv_q : '0;
	assign prog_active_out             = active_q; // [RULE_01]
	assign route_reject_out            = reject_q;
endmodule

// [sim/pis_steering_checker.sv]
// assertion checker for the pci interrupt steering block
`timescale 1ns/1ps
`include "pis_defines.svh"
module pis_steering_checker
	import pis_pkg::*;
#(
	parameter int NUM_PROG = 8,
	parameter int NUM_DYN  = 3
) (
	input wire logic                  ref_clk_in,
	input wire logic                  reset_n_in,
	input wire logic [NUM_PROG-1:0]   prog_irq_input_n_in,
	input wire logic                  adv_mode_in,
	input wire logic [4*NUM_PROG-1:0] prog_route_in,
	input wire logic                  route_load_in,
	input wire logic                  fixed_load_in,
	input wire logic [NUM_DYN-1:0]    dyn_req_in,
	input wire logic [15:0]           legacy_irq_controller_out,
	input wire logic [23:0]           advanced_irq_controller_out,
	input wire logic [NUM_PROG-1:0]   prog_active_out,
	input wire logic                  route_reject_out
);
	function automatic logic bad(input logic [4*NUM_PROG-1:0] r);
		logic [15:0] m;
		m = `PIS_LEGACY_OK_MASK | 16'h0001;
		bad = 1'b0;
		for (int j = 0; j < NUM_PROG; j++) bad |= !m[r[4*j+:4]];
	endfunction
	// =======
	// checks
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!reset_n_in);
	chk_cascade_free: assert property (!legacy_irq_controller_out[2])
		else $error("line two driven");
	chk_high_quiet: assert property ((!adv_mode_in)[*4] |-> advanced_irq_controller_out[23:16] == 8'h00)
		else $error("upper inputs active in legacy mode");
	chk_legacy_off: assert property (adv_mode_in[*4] |-> legacy_irq_controller_out == 16'h0000)
		else $error("legacy lines active in advanced mode");
	chk_adv_order: assert property (
		($stable(prog_irq_input_n_in) && dyn_req_in == '0 && adv_mode_in)[*5]
		|-> advanced_irq_controller_out[23:16] == ~prog_irq_input_n_in) else $error("advanced order wrong");
	chk_active_level: assert property (
		($stable(prog_irq_input_n_in) && dyn_req_in == '0)[*5] |-> prog_active_out == ~prog_irq_input_n_in)
		else $error("active vector wrong");
	chk_reject_cause: assert property (route_reject_out |-> $past(route_load_in || fixed_load_in))
		else $error("reject without load");
	chk_reject_exact: assert property (
		route_load_in && !fixed_load_in |=> route_reject_out == bad($past(prog_route_in))) else $error("reject wrong");
	chk_reset_clear: assert property (disable iff (1'b0) !reset_n_in |=>
		advanced_irq_controller_out == '0 && legacy_irq_controller_out == '0 && !route_reject_out)
		else $error("outputs not clear in reset");
	cov_reject: cover property (route_reject_out);
	cov_adv: cover property (adv_mode_in && |advanced_irq_controller_out[23:16]);
	cov_leg: cover property (|legacy_irq_controller_out);
endmodule
bind pis_steering pis_steering_checker #(.NUM_PROG(NUM_PROG), .NUM_DYN(NUM_DYN)) u_chk (
	.ref_clk_in                  (ref_clk_in),
	.reset_n_in                  (reset_n_in),
	.prog_irq_input_n_in         (prog_irq_input_n_in),
	.adv_mode_in                 (adv_mode_in),
	.prog_route_in               (prog_route_in),
	.route_load_in               (route_load_in),
	.fixed_load_in               (fixed_load_in),
	.dyn_req_in                  (dyn_req_in),
	.legacy_irq_controller_out   (legacy_irq_controller_out),
	.advanced_irq_controller_out (advanced_irq_controller_out),
	.prog_active_out             (prog_active_out),
	.route_reject_out            (route_reject_out)
);

// [sim/pis_pci_cards.sv]
// pci card and onboard device model driving the request lines
`timescale 1ns/1ps
module pis_pci_cards (
	input  wire logic [3:0] card1_req_in,
	input  wire logic [3:0] card2_req_in,
	input  wire logic [4:0] onboard_req_in,
	output wire logic [7:0] prog_irq_input_n_out
);
	// =======
	// open-drain lines, pull-up: released line reads high
	// single-interrupt cards use bit 0, their first pin
	assign prog_irq_input_n_out = ~{card1_req_in[2] | card2_req_in[3], card1_req_in[1] | card2_req_in[0],
		card1_req_in[0] | card2_req_in[1], card1_req_in[3] | card2_req_in[2] | onboard_req_in[4],
		onboard_req_in[3:0]};
endmodule

// [sim/test_pci_interrupt_steering.sv]
// testbench for the pci interrupt steering block
`timescale 1ns/1ps
module test_pci_interrupt_steering;
	logic        clk = 0;
	logic        rst_n = 0;
	logic        adv = 0;
	logic        rl = 0;
	logic        fl = 0;
	logic        dl = 0;
	logic [3:0]  c1 = '0;
	logic [3:0]  c2 = '0;
	logic [4:0]  onb = '0;
	logic [31:0] rt = '0;
	logic [15:0] fr = '0;
	logic [3:0]  fq = '0;
	logic [2:0]  dq = '0;
	logic [8:0]  ds = '0;
	wire  [7:0]  pn;
	wire  [7:0]  act;
	wire  [15:0] leg;
	wire  [23:0] advo;
	wire         rej;
	integer      seed = 37;
	integer      n_errors = 0;
	integer      samples_checked = 0;
	integer      i;
	integer      k;
	logic [7:0]  a;
	logic [31:0] r;
	logic [3:0]  lv [12] = '{4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hB, 4'hC, 4'hE, 4'hF};
	pis_pci_cards cards (.card1_req_in(c1), .card2_req_in(c2), .onboard_req_in(onb), .prog_irq_input_n_out(pn));
	pis_steering dut (.ref_clk_in(clk), .reset_n_in(rst_n), .prog_irq_input_n_in(pn), .adv_mode_in(adv),
		.prog_route_in(rt), .route_load_in(rl), .fixed_req_in(fq), .fixed_route_in(fr), .fixed_load_in(fl),
		.dyn_req_in(dq), .dyn_sel_in(ds), .dyn_load_in(dl), .legacy_irq_controller_out(leg),
		.advanced_irq_controller_out(advo), .prog_active_out(act), .route_reject_out(rej));
	initial forever #12.5 clk = ~clk;
	// =======
	// helpers
	task step(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task cmp(input string nm, input logic [23:0] e, input logic [23:0] g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	function automatic logic [15:0] exp_leg(input logic [31:0] rr, input logic [7:0] aa);
		exp_leg = '0;
		for (int j = 0; j < 8; j++) if (aa[j] && rr[4*j+:4] != 4'h0) exp_leg[rr[4*j+:4]] = 1'b1;
	endfunction
	task setp(input logic [7:0] v);
		onb = v[4:0];
		c1 = {1'b0, v[7:5]};
	endtask
	task load(input logic [31:0] v);
		rt = v;
		rl = 1;
		step(1);
		rl = 0;
	endtask
	task final_report;
		$display("checked %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// =======
	// scenarios
	initial begin
		step(16);
		rst_n = 1;
		for (k = 0; k < 40; k++) begin
			for (i = 0; i < 8; i++) r[4*i+:4] = lv[$unsigned($random(seed)) % 12];
			a = $random(seed);
			load(r);
			setp(a);
			step(6);
			cmp("legacy", exp_leg(r, a), leg);
			cmp("active", a, act);
			cmp("adv_hi", 0, advo[23:16]);
		end
		$display("legacy steering test done");
		load(32'h000000F3);
		step(1);
		load(32'h00000D29);
		cmp("reject", 1, rej);
		setp(8'h07);
		step(6);
		cmp("legacy_kept", 16'h8200, leg);
		ds = 9'h003;
		dl = 1;
		step(1);
		dl = 0;
		dq = 3'h1;
		setp(8'h00);
		step(6);
		cmp("dyn_active", 8'h08, act);
		dq = '0;
		fr = 16'h2C6A;
		fl = 1;
		step(1);
		fl = 0;
		cmp("reject", 1, rej);
		fq = 4'hF;
		step(6);
		cmp("fixed", 16'h1460, leg);
		fq = '0;
		$display("refusal and source test done");
		adv = 1;
		for (k = 0; k < 20; k++) begin
			a = $random(seed);
			setp(a);
			step(6);
			cmp("adv_hi", a, advo[23:16]);
			cmp("legacy_off", 0, leg);
		end
		setp(8'h00);
		c1 = 4'h8;
		c2 = 4'h4;
		onb = 5'h10;
		step(6);
		cmp("shared", 1, advo[20]);
		onb = '0;
		c1 = '0;
		step(6);
		cmp("shared", 1, advo[20]);
		c2 = '0;
		step(6);
		cmp("shared", 0, advo[20]);
		fq = 4'hF;
		step(6);
		cmp("adv_lo", 16'h1460, advo[15:0]);
		cmp("legacy_off", 0, leg);
		fq = '0;
		$display("advanced mode test done");
		final_report();
	end
endmodule
